// ==== common/sac_cnt_if.sv ====
interface sac_cnt_if;
    logic load;
    logic [15:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

// ==== common/sac_pkg.sv ====
package sac_pkg;
    // conversion and calibration intervals in ns, figures of our own
    localparam int CONV_TIME_NS = 400;
    localparam int CAL_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 25;
    // both intervals round down to whole cycles, never below one cycle
    localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (CONV_TIME_NS / CLK_PERIOD_NS);
    localparam int CAL_CYCLES = (CAL_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (CAL_TIME_NS / CLK_PERIOD_NS);
    localparam int CNT_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_CAL = 2'b10,
        ST_RST = 2'b11
    } sac_state_type;
endpackage

// ==== sim/sac_control_asserts.sv ====
module sac_control_asserts #(parameter int CONV_CYCLES = 16, CAL_CYCLES = 80) (
    input wire logic clk_i, rst_i, reset_in_i, power_down_in_i, convert_start_n_i,
    input wire logic chip_select_n_i, read_n_i, int_reference_off_i, busy_o, hold_o,
    input wire logic int_reference_en_o, data_oe_n_o,
    input wire logic [15:0] core_result_i, data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_bus_on: assert property (data_oe_n_o == (chip_select_n_i | read_n_i))
        else $error("oe");
    a_rst_abort: assert property (reset_in_i |=> !busy_o) else $error("rst");
    a_cal_len: assert property ($fell(busy_o) && !$past(hold_o) && !$past(reset_in_i)
        |-> $past(busy_o, CAL_CYCLES) && !$past(busy_o, CAL_CYCLES + 1)) else $error("cal");
    a_pd_block: assert property (power_down_in_i && !busy_o |=> !hold_o) else $error("pd");
    a_conv_go: assert property ($fell(convert_start_n_i) && !busy_o && !reset_in_i
        && !$past(reset_in_i) && !power_down_in_i |=> hold_o) else $error("go");
    a_conv_end: assert property ($fell(busy_o) && $past(hold_o) && !$past(reset_in_i)
        |-> data_o == $past(core_result_i) && $past(hold_o, CONV_CYCLES)) else $error("end");
    a_ref_on: assert property (int_reference_en_o != int_reference_off_i) else $error("ref");
    a_cal_quiet: assert property (busy_o && !hold_o |=> !hold_o) else $error("q");
    cover property ($rose(hold_o));
    cover property ($rose(busy_o) && !hold_o);
    cover property (!data_oe_n_o);
endmodule // sac_control_asserts
bind sac_control sac_control_asserts #(.CONV_CYCLES(CONV_CYCLES), .CAL_CYCLES(CAL_CYCLES))
    i_sac_control_asserts (.*);

// ==== sim/sac_control_tb.sv ====
module sac_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0, rst_i = 1'h1, reset_in_i = 1'h0, power_down_in_i = 1'h0, go = 1'h0;
    logic chip_select_n_i, read_n_i, int_reference_off_i, ref_buffer_off_i, busy_o, hold_o;
    logic convert_start_n_i, low_power_o, int_reference_en_o, ref_buffer_en_o, data_oe_n_o;
    logic ext_reference_needed_o, ext_bandgap_mode_o;
    logic [15:0] core_result_i = 16'h0000, data_o;
    logic [8:0] rows [4] = '{9'h00C, 9'h0D7, 9'h172, 9'h19C};
    wire [4:0] pins = {data_oe_n_o, int_reference_en_o, ref_buffer_en_o,
        ext_reference_needed_o, ext_bandgap_mode_o};
    int err_total = 0, n_compared = 0, cyc = 0, n;
    always #12.5 clk_i = !clk_i;
    sac_host_model i_sac_host_model (.clk_i, .go_i(go), .convert_start_n_o(convert_start_n_i));
    sac_control #(.CONV_CYCLES(4), .CAL_CYCLES(6)) i_sac_control (.*);
    task automatic chk(input string s, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) if (++cyc > 2000) begin
        err_total++;
        finish_test();
    end
    task automatic start();
        go <= 1'h1;
        @(negedge clk_i);
        go <= 1'h0;
    endtask
    // busy length in cycles, zero when it never rises
    task automatic blen();
        n = 0;
        repeat (20) if (busy_o !== 1'h1) @(negedge clk_i);
        while (busy_o === 1'h1 && n < 99) begin
            n++;
            @(negedge clk_i);
        end
    endtask
    initial begin
        {chip_select_n_i, read_n_i, int_reference_off_i, ref_buffer_off_i} = 4'hC;
        repeat (5) @(negedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        chk("rst", 16'h0000, data_o);
        foreach (rows[i]) begin
            {chip_select_n_i, read_n_i, int_reference_off_i, ref_buffer_off_i} <= rows[i][8:5];
            @(negedge clk_i);
            chk("pins", 16'(rows[i][4:0]), 16'(pins));
        end
        reset_in_i <= 1'h1;
        repeat (2) @(negedge clk_i);
        reset_in_i <= 1'h0;
        start();
        blen();
        chk("cal", 16'h0006, 16'(n));
        blen();
        chk("ign", 16'h0000, 16'(n));
        core_result_i <= 16'hA5C3;
        start();
        blen();
        chk("conv", 16'h0004, 16'(n));
        chk("res", 16'hA5C3, data_o);
        core_result_i <= 16'h3C5A;
        start();
        repeat (2) @(negedge clk_i);
        reset_in_i <= 1'h1;
        repeat (2) @(negedge clk_i);
        chk("abort", 16'h0000, 16'(busy_o));
        reset_in_i <= 1'h0;
        blen();
        chk("kept", 16'hA5C3, data_o);
        start();
        @(negedge clk_i);
        power_down_in_i <= 1'h1;
        blen();
        chk("pdfin", 16'h0004, 16'(n));
        start();
        blen();
        chk("pdoff", 16'h0000, 16'(n));
        chk("lowp", 16'h0001, 16'(low_power_o));
        finish_test();
    end
endmodule // sac_control_tb

// ==== sim/sac_host_model.sv ====
module sac_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    output logic convert_start_n_o = 1'h1
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(negedge clk_i) convert_start_n_o <= !go_i;
endmodule // sac_host_model

// ==== src/sac_control.sv ====
module sac_control #(
    parameter int CONV_CYCLES = sac_pkg::CONV_CYCLES,
    parameter int CAL_CYCLES = sac_pkg::CAL_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control pins
    input wire logic reset_in_i,
    input wire logic power_down_in_i,
    input wire logic convert_start_n_i,
    input wire logic chip_select_n_i,
    input wire logic read_n_i,
    input wire logic int_reference_off_i,
    input wire logic ref_buffer_off_i,
    // result from the analog core
    input wire logic [15:0] core_result_i,
    // status and analog control
    output logic busy_o,
    output logic hold_o,
    output logic low_power_o,
    output logic int_reference_en_o,
    output logic ref_buffer_en_o,
    output logic ext_reference_needed_o,
    output logic ext_bandgap_mode_o,
    // result bus
    output logic [15:0] data_o,
    output logic data_oe_n_o
);
    sac_pkg::sac_state_type state_r;
    sac_pkg::sac_state_type state_nxt;
    logic convert_start_n_prev_r;
    logic reset_prev_r;
    logic [15:0] result_r;
    logic cnv_fall;
    logic rst_fall;
    logic start_ok;
    sac_cnt_if cnt ();

    // pins taken as synchronous, edges found against last sample
    assign cnv_fall = convert_start_n_prev_r && !convert_start_n_i;
    assign rst_fall = reset_prev_r && !reset_in_i;
    // pd checked only at idle so a running conversion completes
    assign start_ok = cnv_fall && (state_r == sac_pkg::ST_IDLE) && !power_down_in_i;

    always_comb begin
        state_nxt = state_r;
        cnt.load = 1'b0;
        cnt.count = 16'h0000;
        unique case (state_r)
            sac_pkg::ST_RST: begin
                if (rst_fall) begin
                    state_nxt = sac_pkg::ST_CAL;
                    cnt.load = 1'b1;
                    cnt.count = 16'(CAL_CYCLES);
                end
            end
            sac_pkg::ST_CAL: begin
                if (cnt.done) begin
                    state_nxt = sac_pkg::ST_IDLE;
                end
            end
            sac_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = sac_pkg::ST_CONV;
                    cnt.load = 1'b1;
                    cnt.count = 16'(CONV_CYCLES);
                end
            end
            sac_pkg::ST_CONV: begin
                if (cnt.done) begin
                    state_nxt = sac_pkg::ST_IDLE;
                end
            end
        endcase
        if (reset_in_i) begin
            state_nxt = sac_pkg::ST_RST;
        end
    end

    sac_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .abort_i(reset_in_i),
        .cnt(cnt)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= sac_pkg::ST_IDLE;
            convert_start_n_prev_r <= 1'b1;
            reset_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            convert_start_n_prev_r <= convert_start_n_i;
            reset_prev_r <= reset_in_i;
        end
    end

    // result latched as conversion ends; aborted ones keep the old value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= sac_pkg::RESULT_RST;
        end else if (state_r == sac_pkg::ST_CONV && cnt.done && !reset_in_i) begin
            result_r <= core_result_i;
        end
    end

    assign busy_o = (state_r == sac_pkg::ST_CONV) || (state_r == sac_pkg::ST_CAL);
    assign hold_o = (state_r == sac_pkg::ST_CONV);
    assign low_power_o = power_down_in_i && (state_r == sac_pkg::ST_IDLE);
    assign int_reference_en_o = !int_reference_off_i;
    assign ext_reference_needed_o = int_reference_off_i;
    assign ref_buffer_en_o = !ref_buffer_off_i;
    assign ext_bandgap_mode_o = int_reference_off_i && !ref_buffer_off_i;
    assign data_oe_n_o = chip_select_n_i || read_n_i;
    assign data_o = result_r;
endmodule // sac_control

// ==== src/sac_timer.sv ====
module sac_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic abort_i,
    sac_cnt_if.timer cnt
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic run_r;

    assign cnt_nxt = cnt_r - 16'h0001;
    assign cnt.done = run_r && (cnt_r == 16'h0001);

    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            cnt_r <= 16'h0000;
            run_r <= 1'b0;
        end else if (cnt.load) begin
            cnt_r <= cnt.count;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_nxt;
            run_r <= (cnt_r != 16'h0001);
        end
    end
endmodule // sac_timer
